// ==== common/sarc_pkg.sv ====
// constants, register map and field layouts for the converter sequencer
// assumes a 250 MHz bus clock and an 8-bit register view on a 32-bit bus
package sarc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_INSEL = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0c;
  localparam logic [7:0] OFF_RES_HI = 8'h10;
  localparam int ADDR_W = 8;

  // ------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic converter_enable;
    logic start_conversion_bit;
    logic auto_trigger_enable;
    logic conversion_done_flag;
    logic rsvd;
    logic [2:0] prescale_select;
  } sarc_ctrl_a_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [3:0] trigger_source_select;
  } sarc_ctrl_b_t;

  typedef struct packed {
    logic [1:0] reference_select;
    logic left_adjust_select;
    logic [4:0] channel_select;
  } sarc_insel_t;

  localparam sarc_ctrl_a_t CTRL_A_RST = 8'h00;
  localparam sarc_ctrl_b_t CTRL_B_RST = 8'h00;
  localparam sarc_insel_t INSEL_RST = 8'h00;

  // trigger source code that means "own done flag": free running
  localparam logic [3:0] TRIG_SELF = 4'h0;

  // ------------------------------------------------------------
  // conversion timing, counted in converter half cycles
  // ------------------------------------------------------------
  localparam int HC_W = 6;
  localparam logic [HC_W-1:0] HC_LEN_NORMAL = 6'h1f; // 15.5 cycles
  localparam logic [HC_W-1:0] HC_LEN_FIRST = 6'h32;  // 25 cycles
  localparam logic [HC_W-1:0] HC_LEN_AUTO = 6'h20;   // 16 cycles
  localparam logic [HC_W-1:0] HC_SH_NORMAL = 6'h07;  // 3.5 cycles
  localparam logic [HC_W-1:0] HC_SH_FIRST = 6'h1b;   // 13.5 cycles
  localparam logic [HC_W-1:0] HC_SH_AUTO = 6'h04;    // 2 cycles
  localparam logic [HC_W-1:0] HC_TRACK = 6'h10;      // last 8 cycles
  localparam int TRIG_SYNC = 3;                      // cpu cycles

  localparam int PS_W = 8;
  localparam int RES_W = 10;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_CONV = 2'b10
  } sarc_seq_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== hdl/sarc_top.sv ====
// sequencer and register file of a 10-bit successive-approximation converter
// assumes an analog macro that samples on sample_hold and presents its code on
// ana_result by the end of each conversion; trigger inputs are synchronous to aclk
//
// Summary of operation
// R01: result right-justified by default, left-justified when left adjust is set.
// R02: reading low byte freezes both result bytes until high byte is read.
// R03: done flag still sets when a completed result is discarded.
// R04: writing start begins one conversion; start reads one until completion.
// R05: channel change mid-conversion takes effect after the ongoing conversion.
// R06: auto-trigger rising edge resets prescaler and starts a conversion.
// R07: trigger edges during conversion ignored; held level never restarts.
// R08: trigger flag is set regardless of enables; software clears it for rearm. No trigger flag here; edges act only with enable and auto-trigger set.
// R09: done-flag trigger restarts after every completion; first start is manual.
// R10: software must not free-run on gain-amplified differential channels.
// R11: start still launches conversions in auto mode; reads one while converting.
// R12: prescaler divides by selected ratio, held reset while enable is low.
// R13: software keeps converter clock 50 kHz to 2 MHz for full resolution.
// R14: manual single-ended conversion begins at next converter clock rising edge.
// R15: normal conversion 15.5 cycles, first after enable 25 cycles.
// R16: sample-hold 3.5 cycles into normal, 13.5 into first conversion.
// R17: completion writes result, sets done, clears start in single mode.
// R18: auto conversion samples two cycles after edge plus three sync cycles, 16 long.
// R19: free running restarts right after completion, start stays high.
// R20: reference selection drives reference network even while disabled.
// R21: selections latched at start, tracked again in last eight cycles.
// R22: left adjust puts bits 9..2 high, 1..0 at top of low byte.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sarc_top #(
  parameter int NTRIG = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sarc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sarc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NTRIG-1:0] trig_in,
  input wire logic [sarc_pkg::RES_W-1:0] ana_result,
  output logic sample_hold,
  output logic conv_active,
  output logic [4:0] channel_out,
  output logic [1:0] reference_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [sarc_pkg::PS_W-1:0] half_period(input logic [2:0] sel);
    half_period = sarc_pkg::PS_W'(1) << sel;
  endfunction

  function automatic logic is_addr(input logic [sarc_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    is_addr = (a == off);
  endfunction

  sarc_pkg::sarc_ctrl_a_t ctla_q;
  sarc_pkg::sarc_ctrl_b_t ctlb_q;
  sarc_pkg::sarc_insel_t insel_q;
  sarc_pkg::sarc_seq_t seq_q;
  logic [sarc_pkg::RES_W-1:0] res_q;
  logic lock_q;
  logic first_q;
  logic free_q;
  logic auto_q;
  logic [sarc_pkg::HC_W-1:0] hc_q;
  logic [sarc_pkg::PS_W-1:0] ps_q;
  logic phase_q;
  logic trig_prev_q;
  logic [sarc_pkg::TRIG_SYNC-1:0] trig_pipe_q;

  // bus side
  logic aw_have_q, w_have_q;
  logic [sarc_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_go;
  logic rd_go;

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sarc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (is_addr(awaddr_q, sarc_pkg::OFF_CTRL_A) || is_addr(awaddr_q, sarc_pkg::OFF_CTRL_B) ||
            is_addr(awaddr_q, sarc_pkg::OFF_INSEL) || is_addr(awaddr_q, sarc_pkg::OFF_RES_LO) ||
            is_addr(awaddr_q, sarc_pkg::OFF_RES_HI)) begin
          s_axi_bresp <= sarc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= sarc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // ------------------------------------------------------------
  // read channel; result reads move the result lock
  // ------------------------------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sarc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sarc_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (is_addr(s_axi_araddr, sarc_pkg::OFF_CTRL_A)) begin
          s_axi_rdata[7:0] <= {ctla_q.converter_enable, (seq_q != sarc_pkg::SEQ_IDLE), // R04 R11
                               ctla_q.auto_trigger_enable, ctla_q.conversion_done_flag,
                               1'b0, ctla_q.prescale_select};
        end else if (is_addr(s_axi_araddr, sarc_pkg::OFF_CTRL_B)) begin
          s_axi_rdata[7:0] <= {4'h0, ctlb_q.trigger_source_select};
        end else if (is_addr(s_axi_araddr, sarc_pkg::OFF_INSEL)) begin
          s_axi_rdata[7:0] <= insel_q;
        end else if (is_addr(s_axi_araddr, sarc_pkg::OFF_RES_LO)) begin
          if (insel_q.left_adjust_select) begin
            s_axi_rdata[7:0] <= {res_q[1:0], 6'h00}; // R22
          end else begin
            s_axi_rdata[7:0] <= res_q[7:0]; // R01
          end
        end else if (is_addr(s_axi_araddr, sarc_pkg::OFF_RES_HI)) begin
          if (insel_q.left_adjust_select) begin
            s_axi_rdata[7:0] <= res_q[9:2]; // R22
          end else begin
            s_axi_rdata[7:0] <= {6'h00, res_q[9:8]}; // R01
          end
        end else begin
          s_axi_rresp <= sarc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // prescaler: half-period ticks, odd ticks are rising edges
  // ------------------------------------------------------------
  logic tick;
  logic rise;
  logic trig_fire;
  logic done_evt;

  // >= so a ratio cut mid-count ticks at once instead of waiting for the counter to wrap
  assign tick = (ps_q >= half_period(ctla_q.prescale_select) - sarc_pkg::PS_W'(1));
  assign rise = tick && !phase_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctla_q.converter_enable || trig_fire) begin // R12 R06
      ps_q <= '0;
      phase_q <= 1'b0;
    end else if (tick) begin
      ps_q <= '0; // R12
      phase_q <= !phase_q;
    end else begin
      ps_q <= ps_q + sarc_pkg::PS_W'(1);
    end
  end

  // ------------------------------------------------------------
  // trigger edge detect and synchroniser delay
  // ------------------------------------------------------------
  logic trig_lvl;
  assign trig_lvl = trig_in[ctlb_q.trigger_source_select];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
      trig_pipe_q <= '0;
    end else begin
      trig_prev_q <= trig_lvl;
      trig_pipe_q <= {trig_pipe_q[sarc_pkg::TRIG_SYNC-2:0], trig_lvl && !trig_prev_q}; // R07 R18
    end
  end

  // held level gives no new edge, and edges while busy drop out here
  assign trig_fire = ctla_q.converter_enable && ctla_q.auto_trigger_enable &&
                     (ctlb_q.trigger_source_select != sarc_pkg::TRIG_SELF) &&
                     trig_pipe_q[sarc_pkg::TRIG_SYNC-1] && (seq_q != sarc_pkg::SEQ_CONV); // R06 R07 R08

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  logic [sarc_pkg::HC_W-1:0] len;
  logic [sarc_pkg::HC_W-1:0] shp;
  logic start_wr;
  logic self_trig;

  always_comb begin
    if (first_q) begin
      len = sarc_pkg::HC_LEN_FIRST; // R15
      shp = sarc_pkg::HC_SH_FIRST; // R16
    end else if (auto_q) begin
      len = sarc_pkg::HC_LEN_AUTO; // R18
      shp = sarc_pkg::HC_SH_AUTO; // R18
    end else begin
      len = sarc_pkg::HC_LEN_NORMAL; // R15
      shp = sarc_pkg::HC_SH_NORMAL; // R16
    end
  end

  assign done_evt = (seq_q == sarc_pkg::SEQ_CONV) && tick && (hc_q == len - sarc_pkg::HC_W'(1));
  assign start_wr = wr_go && wlane_q && is_addr(awaddr_q, sarc_pkg::OFF_CTRL_A) &&
                    wbyte_q[6] && wbyte_q[7];
  assign self_trig = ctla_q.auto_trigger_enable && (ctlb_q.trigger_source_select == sarc_pkg::TRIG_SELF);

  always_ff @(posedge aclk) begin
    if (!aresetn || (!ctla_q.converter_enable && !start_wr)) begin // enabling write may carry start
      seq_q <= sarc_pkg::SEQ_IDLE;
      hc_q <= '0;
      auto_q <= 1'b0;
      free_q <= 1'b0;
      sample_hold <= 1'b0;
      conv_active <= 1'b0;
    end else begin
      sample_hold <= 1'b0;
      case (seq_q)
        sarc_pkg::SEQ_IDLE: begin
          if (trig_fire) begin
            seq_q <= sarc_pkg::SEQ_CONV; // R06
            auto_q <= 1'b1;
            hc_q <= '0;
            conv_active <= 1'b1;
          end else if (start_wr) begin
            seq_q <= sarc_pkg::SEQ_WAIT; // R04 R11
          end
        end
        sarc_pkg::SEQ_WAIT: begin
          if (trig_fire) begin
            seq_q <= sarc_pkg::SEQ_CONV;
            auto_q <= 1'b1;
            hc_q <= '0;
            conv_active <= 1'b1;
          end else if (rise) begin
            seq_q <= sarc_pkg::SEQ_CONV; // R14
            auto_q <= 1'b0;
            free_q <= self_trig; // R09
            hc_q <= '0;
            conv_active <= 1'b1;
          end
        end
        sarc_pkg::SEQ_CONV: begin
          if (tick) begin
            hc_q <= hc_q + sarc_pkg::HC_W'(1);
            if (hc_q == shp - sarc_pkg::HC_W'(1)) begin
              sample_hold <= 1'b1; // R16 R18
            end
          end
          if (done_evt) begin
            hc_q <= '0;
            auto_q <= 1'b0;
            if (self_trig && (free_q || !auto_q)) begin
              free_q <= 1'b1; // R09 R19
            end else begin
              seq_q <= sarc_pkg::SEQ_IDLE; // R17
              free_q <= 1'b0;
              conv_active <= 1'b0;
            end
          end
        end
        default: begin
          seq_q <= sarc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // first conversion after enable runs long
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctla_q.converter_enable) begin
      first_q <= 1'b1;
    end else if (done_evt) begin
      first_q <= 1'b0; // R15
    end
  end

  // ------------------------------------------------------------
  // result register and read lock
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (rd_go && is_addr(s_axi_araddr, sarc_pkg::OFF_RES_HI)) begin
      lock_q <= 1'b0; // R02
    end else if (rd_go && is_addr(s_axi_araddr, sarc_pkg::OFF_RES_LO)) begin
      lock_q <= 1'b1; // R02
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= '0;
    end else if (done_evt && !lock_q) begin
      res_q <= ana_result; // R17 R02
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctla_q <= sarc_pkg::CTRL_A_RST;
      ctlb_q <= sarc_pkg::CTRL_B_RST;
      insel_q <= sarc_pkg::INSEL_RST;
    end else begin
      if (wr_go && wlane_q) begin
        if (is_addr(awaddr_q, sarc_pkg::OFF_CTRL_A)) begin
          ctla_q.converter_enable <= wbyte_q[7];
          ctla_q.auto_trigger_enable <= wbyte_q[5];
          ctla_q.prescale_select <= wbyte_q[2:0];
          if (wbyte_q[4]) begin
            ctla_q.conversion_done_flag <= 1'b0;
          end
        end else if (is_addr(awaddr_q, sarc_pkg::OFF_CTRL_B)) begin
          ctlb_q.trigger_source_select <= wbyte_q[3:0];
        end else if (is_addr(awaddr_q, sarc_pkg::OFF_INSEL)) begin
          insel_q <= wbyte_q;
        end
      end
      // completion wins over a same-cycle clear
      if (done_evt) begin
        ctla_q.conversion_done_flag <= 1'b1; // R03 R17
      end
      ctla_q.start_conversion_bit <= 1'b0;
      ctla_q.rsvd <= 1'b0;
      ctlb_q.rsvd <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // selections to the analog side
  // ------------------------------------------------------------
  logic tracking;
  assign tracking = (seq_q != sarc_pkg::SEQ_CONV) || (len - hc_q <= sarc_pkg::HC_TRACK); // R21

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_out <= sarc_pkg::INSEL_RST.channel_select;
      reference_out <= sarc_pkg::INSEL_RST.reference_select;
    end else if (tracking) begin
      channel_out <= insel_q.channel_select; // R05 R21
      reference_out <= insel_q.reference_select; // R20 R21
    end
  end

endmodule

// ==== tb/sarc_monitor.sv ====
// port-level checks of the converter sequencer
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module sarc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_hold,
  input wire logic conv_active,
  input wire logic [4:0] channel_out,
  input wire logic [1:0] reference_out
);
  logic sh_seen_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------------------------------
  // helper
  // --------------------------------------------------------
  // free run keeps this set, which only weakens the latch check there
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_active) begin
      sh_seen_q <= 1'h0;
    end else if (sample_hold) begin
      sh_seen_q <= 1'h1;
    end
  end
  // --------------------------------------------------------
  // checks
  // --------------------------------------------------------
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_sh_busy: assert property (sample_hold |-> conv_active [*8])
    else $error("sample pulse outside conversion");
  a_sh_pulse: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse too long");
  a_sel_latched: assert property (
    conv_active && $past(conv_active) && !sh_seen_q |-> $stable(channel_out) && $stable(reference_out))
    else $error("selection moved before sampling");
endmodule
bind sarc_top sarc_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_hold(sample_hold),
  .conv_active(conv_active), .channel_out(channel_out), .reference_out(reference_out));

// ==== tb/sarc_analog_model.sv ====
// behavioural analog front end: holds a per-channel code from the sample pulse
// assumes the code is read only from the sample instant to the end of a conversion
`timescale 1ns/1ps
module sarc_analog_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_hold,
  input wire logic conv_active,
  input wire logic [4:0] channel_out,
  output logic [9:0] ana_result
);
  logic [9:0] held_q;
  // code depends on channel so a wrong channel shows in the result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= 10'h0;
    end else if (sample_hold) begin
      held_q <= {channel_out, channel_out};
    end
  end
  // not valid outside a conversion, so show junk there
  assign ana_result = conv_active ? held_q : ~held_q;
endmodule

// ==== tb/sarc_top_test.sv ====
// self-checking bench: registers, single, locked, auto and free-running conversions
// assumes sarc_pkg, the analog model and the monitor are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module sarc_top_test;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] trig = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, sh, busy;
  logic [1:0] bresp, rresp, refo, r;
  logic [31:0] rdata;
  logic [9:0] code;
  logic [4:0] cho;
  logic [7:0] d;
  int bad_count = 0, compares = 0, run = 0, len = 0, sh_at = 0, nfall = 0, nsh = 0;
  always #2 aclk = ~aclk;
  sarc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in(trig),
    .ana_result(code), .sample_hold(sh), .conv_active(busy), .channel_out(cho), .reference_out(refo));
  sarc_analog_model model (.aclk(aclk), .aresetn(aresetn), .sample_hold(sh), .conv_active(busy),
    .channel_out(cho), .ana_result(code));
  // --------------------------------------------------------
  // conversion length and sample offset, in aclk cycles
  // --------------------------------------------------------
  always @(posedge aclk) begin
    if (sh) begin
      sh_at = run;
      nsh++;
    end
    if (busy) begin
      run++;
    end else if (run != 0) begin
      len = run;
      nfall++;
      run = 0;
    end
  end
  // --------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= {24'h0, v};
    wvalid <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        done = 1'h1;
        bready <= 1'h0;
        `CHK(bresp, er)
      end else if (bvalid) bready <= 1'h1;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        done = 1'h1;
        d = rdata[7:0];
        r = rresp;
        rready <= 1'h0;
      end else if (rvalid) rready <= 1'h1;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  task automatic wdone;
    int k0;
    k0 = nfall;
    for (int i = 0; i < 5000 && nfall == k0; i++) @(posedge aclk);
  endtask
  // --------------------------------------------------------
  // scenarios
  // --------------------------------------------------------
  task t_regs;
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    rd(8'h14);
    `CHK(r, sarc_pkg::RESP_SLVERR)
    wr(8'h14, 8'hff, sarc_pkg::RESP_SLVERR);
    wr(8'h10, 8'hff, sarc_pkg::RESP_OKAY);
    rc(8'h0c, 8'h00);
    rc(8'h10, 8'h00);
    $display("t_regs finished");
  endtask
  task t_single;
    wr(8'h08, 8'h1a, sarc_pkg::RESP_OKAY);
    wr(8'h00, 8'hc0, sarc_pkg::RESP_OKAY);
    rc(8'h00, 8'hc0);
    wdone;
    `CHK(len, 50)
    `CHK(sh_at, 27)
    rc(8'h00, 8'h90);
    rc(8'h0c, 8'h5a);
    rc(8'h10, 8'h03);
    // slowest ratio keeps the converter clock inside the full-resolution band
    wr(8'h00, 8'hc7, sarc_pkg::RESP_OKAY);
    wdone;
    `CHK(len, 3968)
    $display("t_single finished");
  endtask
  task t_lock;
    wr(8'h08, 8'h23, sarc_pkg::RESP_OKAY);
    wr(8'h00, 8'hd1, sarc_pkg::RESP_OKAY);
    wr(8'h08, 8'h29, sarc_pkg::RESP_OKAY);
    wdone;
    `CHK(len, 62)
    `CHK(sh_at, 14)
    rc(8'h0c, 8'hc0);
    rc(8'h10, 8'h18);
    wr(8'h00, 8'hd1, sarc_pkg::RESP_OKAY);
    wdone;
    rc(8'h0c, 8'h40);
    wr(8'h08, 8'h3a, sarc_pkg::RESP_OKAY);
    wr(8'h00, 8'hd1, sarc_pkg::RESP_OKAY);
    wdone;
    rc(8'h00, 8'h91);
    rc(8'h10, 8'h4a);
    rc(8'h0c, 8'h40);
    rc(8'h10, 8'h4a);
    $display("t_lock finished");
  endtask
  task t_auto;
    int k0;
    wr(8'h04, 8'h02, sarc_pkg::RESP_OKAY);
    wr(8'h00, 8'hb0, sarc_pkg::RESP_OKAY);
    trig[2] <= 1'h1;
    for (int i = 0; i < 100 && !busy; i++) @(posedge aclk);
    trig[2] <= 1'h0;
    @(posedge aclk);
    trig[2] <= 1'h1;
    wdone;
    `CHK(len, 32)
    `CHK(sh_at, 4)
    k0 = nfall;
    repeat (100) @(posedge aclk);
    `CHK(nfall, k0)
    trig[2] <= 1'h0;
    @(posedge aclk);
    trig[2] <= 1'h1;
    wdone;
    `CHK(nfall, k0 + 1)
    trig[2] <= 1'h0;
    $display("t_auto finished");
  endtask
  task t_free;
    int k0;
    wr(8'h04, 8'h00, sarc_pkg::RESP_OKAY);
    wr(8'h00, 8'he0, sarc_pkg::RESP_OKAY);
    k0 = nsh;
    for (int i = 0; i < 200 && nsh < k0 + 2; i++) @(posedge aclk);
    #1 k0 = nsh;
    repeat (124) @(posedge aclk);
    #1 `CHK(nsh - k0, 4)
    rc(8'h00, 8'hf0);
    k0 = nsh;
    for (int i = 0; i < 200 && nsh == k0; i++) @(posedge aclk);
    // stop well after the sample pulse
    repeat (10) @(posedge aclk);
    wr(8'h00, 8'h00, sarc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1 `CHK(busy, 1'h0)
    wr(8'h08, 8'h80, sarc_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1 `CHK(refo, 2'h2)
    $display("t_free finished");
  endtask
  task end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_single;
    t_lock;
    t_auto;
    t_free;
    end_sim;
  end
  // the whole run needs about 5000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_sim;
  end
endmodule
